// *** pkg/host_serial_pkg.sv ***
/*
  Constants and carrier types for the host serial port with hardware
  handshake. Assumes a single 20 MHz system clock and synchronous pins.
*/
// Contract
// RQ1 - Receive host characters on the TXD input
// RQ2 - Send characters to host on RXD output
// RQ3 - Transmit only while host RTS asserted
// RQ4 - Host negates RTS when not ready
// RQ5 - CTS follows receive buffer room
// RQ6 - Host stops sending while CTS negated
// RQ7 - CTS driven even with software flow control
// RQ8 - DSR held asserted while powered
// RQ9 - DCD follows the connect indicator
// RQ10 - DTR input is ignored
// RQ11 - Unconnected handshake inputs read as asserted
// RQ12 - Baud rates 300 through 19200 selectable
// RQ13 - Seven or eight bits, parity none/even/odd
// RQ14 - Default 1200 8N1, regional 1200 7E1
// RQ15 - Ring position is auxiliary radio carrier detect
// RQ16 - Start low, data LSB first, parity, stop
package host_serial_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ      = 20000000;
  localparam int OVERSAMPLE  = 16;
  localparam int BAUD_300    = 300;
  localparam int BAUD_1200   = 1200;
  localparam int BAUD_2400   = 2400;
  localparam int BAUD_4800   = 4800;
  localparam int BAUD_9600   = 9600;
  localparam int BAUD_19200  = 19200;

  // ****************************************
  // Configuration encodings
  // ****************************************
  localparam logic [2:0] RATE_300   = 3'h0;
  localparam logic [2:0] RATE_1200  = 3'h1;
  localparam logic [2:0] RATE_2400  = 3'h2;
  localparam logic [2:0] RATE_4800  = 3'h3;
  localparam logic [2:0] RATE_9600  = 3'h4;
  localparam logic [2:0] RATE_19200 = 3'h5;

  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_EVEN = 2'h1;
  localparam logic [1:0] PAR_ODD  = 2'h2;

  localparam int RX_FLAG_PARITY = 0;
  localparam int RX_FLAG_FRAME  = 1;

  typedef struct packed {
    logic [2:0] rate;
    logic       sevenBits;
    logic [1:0] parity;
  } serial_cfg_t;

  localparam serial_cfg_t CFG_DEFAULT  = '{rate: RATE_1200, sevenBits: 1'b0, parity: PAR_NONE};
  localparam serial_cfg_t CFG_REGIONAL = '{rate: RATE_1200, sevenBits: 1'b1, parity: PAR_EVEN};

  // Divider for one oversample tick at each rate; 300 baud needs thirteen bits
  function automatic logic [12:0] tick_div(input logic [2:0] rate);
    int baud;
    baud = BAUD_1200;
    case (rate)
      RATE_300:   baud = BAUD_300;
      RATE_2400:  baud = BAUD_2400;
      RATE_4800:  baud = BAUD_4800;
      RATE_9600:  baud = BAUD_9600;
      RATE_19200: baud = BAUD_19200;
      default:    baud = BAUD_1200;
    endcase
    tick_div = 13'(CLK_HZ / (baud * OVERSAMPLE) - 1);
  endfunction : tick_div

  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_START  = 4'b0010,
    ST_DATA   = 4'b0100,
    ST_STOP   = 4'b1000
  } frame_state_t;

endpackage : host_serial_pkg

// *** rtl/host_serial_port.sv ***
/*
  Host serial port, wired as the modem end: receives on TXD, sends on RXD,
  throttles the host with CTS and obeys the host's RTS. Assumes inputs are
  synchronous to clk_sys and that pulled-up lines arrive as logic one.
*/
`timescale 1ns/10ps
module host_serial_port
  import host_serial_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // Configuration
  input  wire logic        regionalDefault,
  input  wire logic        cfgLoad,
  input  wire serial_cfg_t cfgIn,
  output serial_cfg_t      cfgActive,
  // Host pins
  input  wire logic        txdIn,
  output logic             rxdOut,
  input  wire logic        rtsIn,
  output logic             ctsOut,
  output logic             dsrOut,
  output logic             dcdOut,
  input  wire logic        dtrIn,
  input  wire logic        ringIn,
  // Controller side
  input  wire logic        connect_indicator,
  output logic             aux_radio_carrier_detect,
  input  wire logic [7:0]  txData,
  input  wire logic        txValid,
  output logic             txReady,
  output logic [7:0]       rxData,
  output logic [1:0]       rxFlags,
  output logic             rxValid,
  input  wire logic        rxReady
);

  // ****************************************
  // Configuration and baud tick
  // ****************************************
  logic        strapDone;
  logic [12:0] tickCnt;
  logic        tick;

  // Strap sampled on the first clock after reset release
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfgActive <= CFG_DEFAULT;
      strapDone <= 1'b0;
    end else if (!strapDone) begin
      strapDone <= 1'b1;
      cfgActive <= regionalDefault ? CFG_REGIONAL : CFG_DEFAULT; // [RQ14]
    end else if (cfgLoad) begin
      cfgActive <= cfgIn; // [RQ12] [RQ13]
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tickCnt <= 13'h0000;
    end else if (tick || cfgLoad) begin
      // A new rate takes effect on the very next tick, not after one old period
      tickCnt <= tick_div(cfgLoad ? cfgIn.rate : cfgActive.rate); // [RQ12]
    end else begin
      tickCnt <= tickCnt - 13'h0001;
    end
  end
  assign tick = (tickCnt == 13'h0000);

  // ****************************************
  // Static handshake lines
  // ****************************************
  // DTR is deliberately left unread: the port behaves the same either way
  logic unusedDtr;
  assign unusedDtr = dtrIn; // [RQ10]

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dsrOut                   <= 1'b1;
      dcdOut                   <= 1'b0;
      aux_radio_carrier_detect <= 1'b1;
    end else begin
      dsrOut                   <= 1'b1;               // [RQ8]
      dcdOut                   <= connect_indicator;  // [RQ9]
      aux_radio_carrier_detect <= ringIn;             // [RQ15]
    end
  end

  // ****************************************
  // Transmitter toward the host
  // ****************************************
  frame_state_t txState;
  logic [3:0]   txSub;
  logic [3:0]   txBit;
  logic [8:0]   txShift;
  logic [3:0]   txLen;

  // Frame length in data plus parity bits
  always_comb begin
    txLen = cfgActive.sevenBits ? 4'h7 : 4'h8;
    if (cfgActive.parity != PAR_NONE) begin
      txLen = txLen + 4'h1;
    end
  end

  function automatic logic par_bit(input logic [7:0] d, input serial_cfg_t c);
    logic p;
    p = c.sevenBits ? ^d[6:0] : ^d;
    par_bit = (c.parity == PAR_ODD) ? ~p : p;
  endfunction : par_bit

  // Unconnected RTS is pulled up, so a floating line still lets data flow
  assign txReady = (txState == ST_IDLE) && rtsIn; // [RQ3] [RQ11]

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      txState <= ST_IDLE;
      txSub   <= 4'h0;
      txBit   <= 4'h0;
      txShift <= 9'h1ff;
      rxdOut  <= 1'b1;
    end else begin
      unique case (txState)
        ST_IDLE: begin
          rxdOut <= 1'b1;
          if (txValid && rtsIn) begin // [RQ3]
            txShift <= cfgActive.sevenBits ? {1'b1, par_bit(txData, cfgActive), txData[6:0]}
                                           : {par_bit(txData, cfgActive), txData};
            if (cfgActive.parity == PAR_NONE) begin
              txShift <= cfgActive.sevenBits ? {2'h3, txData[6:0]} : {1'b1, txData};
            end
            txSub   <= 4'h0;
            txState <= ST_START;
          end
        end
        ST_START: begin
          rxdOut <= 1'b0; // [RQ16]
          if (tick) begin
            txSub <= txSub + 4'h1;
            if (txSub == 4'hf) begin
              txBit   <= 4'h0;
              txState <= ST_DATA;
            end
          end
        end
        ST_DATA: begin
          rxdOut <= txShift[0]; // [RQ2] [RQ16]
          if (tick) begin
            txSub <= txSub + 4'h1;
            if (txSub == 4'hf) begin
              txShift <= {1'b1, txShift[8:1]};
              txBit   <= txBit + 4'h1;
              if (txBit == txLen - 4'h1) begin
                txState <= ST_STOP;
              end
            end
          end
        end
        ST_STOP: begin
          rxdOut <= 1'b1; // [RQ16]
          if (tick) begin
            txSub <= txSub + 4'h1;
            if (txSub == 4'hf) begin
              txState <= ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // ****************************************
  // Receiver from the host
  // ****************************************
  frame_state_t rxState;
  logic [3:0]   rxSub;
  logic [3:0]   rxBit;
  logic [8:0]   rxShift;
  logic [7:0]   rxWord;
  logic         rxPerr;

  always_comb begin
    rxWord = cfgActive.sevenBits ? {1'b0, rxShift[8:2]} : rxShift[8:1];
    if (cfgActive.parity == PAR_NONE) begin
      rxWord = cfgActive.sevenBits ? {1'b0, rxShift[8:2]} : rxShift[8:1];
    end else begin
      rxWord = cfgActive.sevenBits ? {1'b0, rxShift[7:1]} : rxShift[7:0];
    end
    rxPerr = (cfgActive.parity != PAR_NONE) &&
             (par_bit(rxWord, cfgActive) != rxShift[8]);
  end

  // One holding word; CTS drops one clock after it is occupied and unread, whether or not a frame is in flight
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rxState <= ST_IDLE;
      rxSub   <= 4'h0;
      rxBit   <= 4'h0;
      rxShift <= 9'h000;
      rxValid <= 1'b0;
      rxData  <= 8'h00;
      rxFlags <= 2'h0;
    end else begin
      if (rxValid && rxReady) begin
        rxValid <= 1'b0;
      end
      unique case (rxState)
        ST_IDLE: begin
          if (!txdIn) begin // [RQ1]
            rxSub   <= 4'h0;
            rxState <= ST_START;
          end
        end
        ST_START: begin
          if (tick) begin
            rxSub <= rxSub + 4'h1;
            if (rxSub == 4'h7) begin
              rxSub   <= 4'h0;
              rxBit   <= 4'h0;
              rxState <= txdIn ? ST_IDLE : ST_DATA; // Glitch rejected [RQ16]
            end
          end
        end
        ST_DATA: begin
          if (tick) begin
            rxSub <= rxSub + 4'h1;
            if (rxSub == 4'hf) begin
              rxShift <= {txdIn, rxShift[8:1]}; // [RQ1] [RQ16]
              rxBit   <= rxBit + 4'h1;
              if (rxBit == txLen - 4'h1) begin
                rxState <= ST_STOP;
              end
            end
          end
        end
        ST_STOP: begin
          if (tick) begin
            rxSub <= rxSub + 4'h1;
            if (rxSub == 4'hf) begin
              // Word ends at the top bit without parity; with parity, at length eight or nine, parity takes the top bit
              rxData                 <= rxWord;
              rxFlags[RX_FLAG_PARITY] <= rxPerr;
              rxFlags[RX_FLAG_FRAME]  <= !txdIn; // [RQ16]
              rxValid                <= 1'b1;
              rxState                <= ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Independent of any software flow control in use above this block
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctsOut <= 1'b0;
    end else begin
      ctsOut <= !rxValid || rxReady; // [RQ5] [RQ7]
    end
  end

endmodule : host_serial_port

// *** verification/host_serial_port_properties.sv ***
/* Pin checker for the host serial port.
   Assumes it is bound to host_serial_port. */
`timescale 1ns/10ps
module host_serial_port_properties
  import host_serial_pkg::*;
(
  // Watched pins
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        cfgLoad,
  input wire serial_cfg_t cfgIn,
  input wire serial_cfg_t cfgActive,
  input wire logic        rxdOut,
  input wire logic        rtsIn,
  input wire logic        ctsOut,
  input wire logic        dsrOut,
  input wire logic        dcdOut,
  input wire logic        ringIn,
  input wire logic        connect_indicator,
  input wire logic        aux_radio_carrier_detect,
  input wire logic        txValid,
  input wire logic        txReady,
  input wire logic [7:0]  rxData,
  input wire logic        rxValid,
  input wire logic        rxReady
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_dsr_always_high: assert property (dsrOut) else $error("dsr low");
  a_dcd_copy: assert property (1 |=> dcdOut == $past(connect_indicator)) else $error("dcd");
  a_aux_copy: assert property (1 |=> aux_radio_carrier_detect == $past(ringIn)) else $error("aux");
  a_rts_gates_tx: assert property (txValid && !rtsIn |-> !txReady) else $error("rts gate");
  a_tx_start_low: assert property (txValid && txReady |=> !txReady ##1 (!rxdOut && !txReady) [*8])
    else $error("start");
  a_cts_tracks: assert property (1 |=> ctsOut == (!$past(rxValid) || $past(rxReady))) else $error("cts");
  a_rx_held: assert property (rxValid && !rxReady |=> rxValid && $stable(rxData)) else $error("rx held");
  a_cfg_loads: assert property (cfgLoad |=> cfgActive == $past(cfgIn)) else $error("cfg");
  a_bit_min_len: assert property ($fell(rxdOut) |-> !rxdOut [*8]) else $error("bit length");
endmodule : host_serial_port_properties

bind host_serial_port host_serial_port_properties chk_i (.clk_sys(clk_sys), .rst_n(rst_n),
  .cfgLoad(cfgLoad), .cfgIn(cfgIn), .cfgActive(cfgActive), .rxdOut(rxdOut), .rtsIn(rtsIn),
  .ctsOut(ctsOut), .dsrOut(dsrOut), .dcdOut(dcdOut), .ringIn(ringIn), .connect_indicator(connect_indicator),
  .aux_radio_carrier_detect(aux_radio_carrier_detect), .txValid(txValid), .txReady(txReady),
  .rxData(rxData), .rxValid(rxValid), .rxReady(rxReady));

// *** verification/host_model.sv ***
/* Host terminal model: sends frames on txd, samples frames on rxd.
   Assumes a bit period of BIT clock cycles. */
`timescale 1ns/10ps
module host_model #(
  parameter int BIT = 1040
) (
  // Pins
  input  wire logic clk_sys,
  input  wire logic rxdOut,
  input  wire logic ctsOut,
  output logic      txdIn,
  output logic      rtsIn
);
  // ****************************************
  // Line drivers and sampler
  // ****************************************
  logic [8:0] bits = 9'h000;
  int         count = 0;
  initial begin
    txdIn = 1'b1;
    rtsIn = 1'b1;
  end
  task automatic setReady(input logic r);
    rtsIn <= r;
  endtask : setReady
  task automatic sendChar(input logic [9:0] f);
    while (ctsOut !== 1'b1) @(posedge clk_sys);
    for (int i = 0; i < 10; i++) begin
      txdIn <= f[i];
      repeat (BIT) @(posedge clk_sys);
    end
  endtask : sendChar
  // Mid-bit sampling tolerates the one-tick start jitter
  always begin
    @(posedge clk_sys);
    if (rxdOut === 1'b0) begin
      repeat (BIT / 2) @(posedge clk_sys);
      for (int i = 0; i < 9; i++) begin
        repeat (BIT) @(posedge clk_sys);
        bits[i] = rxdOut;
      end
      count++;
    end
  end
endmodule : host_model

// *** verification/tb.sv ***
/* Self-checking bench for the host serial port.
   Assumes the host model and bound checker are compiled alongside. */
`timescale 1ns/10ps
module tb;
  import host_serial_pkg::*;
  // ****************************************
  // Bench signals
  // ****************************************
  localparam int BITC = CLK_HZ / (BAUD_19200 * OVERSAMPLE) * OVERSAMPLE;
  localparam serial_cfg_t C8N1 = '{rate: RATE_19200, sevenBits: 1'b0, parity: PAR_NONE};
  localparam serial_cfg_t C7E1 = '{rate: RATE_19200, sevenBits: 1'b1, parity: PAR_EVEN};
  logic clk_sys = 0, rst_n = 0, regionalDefault = 0, cfgLoad = 0, dtrIn = 0, ringIn = 1;
  logic connect_indicator = 0, txValid = 0, rxReady = 0;
  logic [7:0] txData = 8'h00, rxData;
  logic [1:0] rxFlags;
  logic txdIn, rxdOut, rtsIn, ctsOut, dsrOut, dcdOut, aux, txReady, rxValid;
  serial_cfg_t cfgIn = CFG_DEFAULT, cfgActive;
  int badCount = 0, comparisons = 0;
  always #25 clk_sys = ~clk_sys;
  host_serial_port host_serial_port_i (.clk_sys(clk_sys), .rst_n(rst_n), .regionalDefault(regionalDefault),
    .cfgLoad(cfgLoad), .cfgIn(cfgIn), .cfgActive(cfgActive), .txdIn(txdIn), .rxdOut(rxdOut), .rtsIn(rtsIn),
    .ctsOut(ctsOut), .dsrOut(dsrOut), .dcdOut(dcdOut), .dtrIn(dtrIn), .ringIn(ringIn),
    .connect_indicator(connect_indicator), .aux_radio_carrier_detect(aux), .txData(txData),
    .txValid(txValid), .txReady(txReady), .rxData(rxData), .rxFlags(rxFlags), .rxValid(rxValid),
    .rxReady(rxReady));
  host_model #(.BIT(BITC)) host_model_i (.clk_sys(clk_sys), .rxdOut(rxdOut), .ctsOut(ctsOut),
    .txdIn(txdIn), .rtsIn(rtsIn));
  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      badCount++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic giveVerdict;
    if (badCount == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : giveVerdict
  task automatic doReset(input logic strap);
    rst_n <= 1'b0;
    regionalDefault <= strap;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
  endtask : doReset
  task automatic load(input serial_cfg_t c);
    cfgIn <= c;
    cfgLoad <= 1'b1;
    @(posedge clk_sys);
    cfgLoad <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask : load
  // Device sends d and the host model must see frame f
  task automatic devSend(input logic [7:0] d, input logic [8:0] f);
    int n;
    n = host_model_i.count;
    txData <= d;
    txValid <= 1'b1;
    @(negedge clk_sys);
    for (int i = 0; i < 20 && txReady !== 1'b1; i++) @(negedge clk_sys);
    @(posedge clk_sys);
    txValid <= 1'b0;
    for (int i = 0; i < 12 * BITC && host_model_i.count == n; i++) @(posedge clk_sys);
    check("host frame", 16'(f), 16'(host_model_i.bits));
  endtask : devSend
  // Wait for a received character, compare it, then consume it
  task automatic devTake(input logic [7:0] d, input logic [1:0] fl);
    for (int i = 0; i < 3 * BITC && rxValid !== 1'b1; i++) @(posedge clk_sys);
    @(negedge clk_sys);
    check("rx data", 16'(d), 16'(rxData));
    check("rx flags", 16'(fl), 16'(rxFlags));
    check("cts full", 16'h0, 16'(ctsOut));
    @(posedge clk_sys);
    rxReady <= 1'b1;
    @(posedge clk_sys);
    rxReady <= 1'b0;
    repeat (2) @(negedge clk_sys);
    check("cts free", 16'h1, 16'(ctsOut));
    @(posedge clk_sys);
  endtask : devTake
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic tDefaults;
    doReset(1'b0);
    check("default cfg", 16'(CFG_DEFAULT), 16'(cfgActive));
    for (int r = 0; r < 6; r++) begin
      load('{rate: 3'(r), sevenBits: 1'b0, parity: PAR_ODD});
      check("rate", 16'(r), 16'(cfgActive.rate));
    end
    load(C8N1);
  endtask : tDefaults
  task automatic tTxGate;
    host_model_i.setReady(1'b0);
    txValid <= 1'b1;
    repeat (40) @(posedge clk_sys);
    @(negedge clk_sys);
    check("ready held", 16'h0, 16'(txReady));
    check("line idle", 16'h1, 16'(rxdOut));
    @(posedge clk_sys);
    host_model_i.setReady(1'b1);
    devSend(8'h96, {1'b1, 8'h96});
  endtask : tTxGate
  // Second character waits for CTS while the first is unread
  task automatic tRxThrottle;
    dtrIn <= 1'b1;
    host_model_i.sendChar({1'b1, 8'ha5, 1'b0});
    fork
      host_model_i.sendChar({1'b1, 8'h3c, 1'b0});
      begin
        repeat (200) @(negedge clk_sys);
        check("host held", 16'h1, 16'(txdIn));
        devTake(8'ha5, 2'h0);
      end
    join
    devTake(8'h3c, 2'h0);
  endtask : tRxThrottle
  task automatic tParity;
    load(C7E1);
    host_model_i.sendChar({1'b1, 1'b1, 7'h55, 1'b0});
    devTake(8'h55, 2'h1);
    devSend(8'h31, {1'b1, 1'b1, 7'h31});
  endtask : tParity
  task automatic tPins;
    connect_indicator <= 1'b1;
    ringIn <= 1'b0;
    repeat (3) @(negedge clk_sys);
    check("dcd", 16'h1, 16'(dcdOut));
    check("aux carrier", 16'h0, 16'(aux));
    check("dsr", 16'h1, 16'(dsrOut));
    @(posedge clk_sys);
    doReset(1'b1);
    check("regional cfg", 16'(CFG_REGIONAL), 16'(cfgActive));
  endtask : tPins
  initial begin
    tDefaults();
    tTxGate();
    tRxThrottle();
    tParity();
    tPins();
    giveVerdict();
  end
  initial begin
    repeat (90000) @(posedge clk_sys);
    badCount++;
    giveVerdict();
  end
endmodule : tb
